// ==== logic/increment_regs_pkg.sv ====
// Purpose: constants for the oscillator increment register bank
// Assumes: Avalon-MM slave, 32-bit words, byte registers in low bits
// Notes: Operation
// Operation
// - Three bytes form one 20-bit increment
// - Reset sets low byte to 0x01
// - Reset clears high and upper bytes
// - Upper register holds bits 3:0 only
// - Low-byte write loads buffer at source falling edge
// - Two-bit field selects the source clock
package increment_regs_pkg;
  localparam int addr_width = 4;
  localparam logic [3:0] low_offset = 4'h0;
  localparam logic [3:0] high_offset = 4'h4;
  localparam logic [3:0] upper_offset = 4'h8;
  localparam logic [3:0] control_offset = 4'hc;
  localparam logic [7:0] low_reset = 8'h01;
  localparam logic [7:0] high_reset = 8'h00;
  localparam logic [3:0] upper_reset = 4'h0;
  localparam logic [1:0] select_reset = 2'h0;
  localparam int upper_msb = 19;
  localparam int high_msb = 15;
  localparam int low_msb = 7;
  typedef enum logic [1:0] {
    src_fast_osc_type = 2'b00,
    src_system_type = 2'b01,
    src_logic_cell_type = 2'b10,
    src_reserved_type = 2'b11
  } source_select_type;
endpackage

// ==== logic/source_edge_if.sv ====
`timescale 1ns/1ps
interface source_edge_if;
  logic [1:0] select;
  logic fast_osc;
  logic logic_cell;
  logic fall;
  modport owner (output select, output fast_osc, output logic_cell, input fall);
  modport detector (input select, input fast_osc, input logic_cell, output fall);
endinterface

// ==== logic/source_edge_detect.sv ====
`timescale 1ns/1ps
// Purpose: pick the oscillator source clock and flag its falling edges
// Assumes: source levels are synchronous to sys_clk_i
// Notes: system clock source falls once per sys_clk_i cycle
module source_edge_detect
  import increment_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  source_edge_if.detector sel
);
  logic src_lvl;
  logic prev_ff;

  always_comb
  begin
    unique case (sel.select)
      src_fast_osc_type: src_lvl = sel.fast_osc;
      src_logic_cell_type: src_lvl = sel.logic_cell;
      default: src_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      prev_ff <= 1'b0;
    else if (ce_i)
      prev_ff <= src_lvl;
  end

  // Reserved code never produces an edge
  assign sel.fall = (sel.select == src_system_type) ? 1'b1 :
                    ((sel.select == src_reserved_type) ? 1'b0 : (prev_ff & ~src_lvl));
endmodule

// ==== logic/oscillator_increment_regs.sv ====
`timescale 1ns/1ps
// Purpose: increment registers and double buffer of the oscillator
// Assumes: Avalon-MM slave, one request at a time
// Notes: waitrequest is high for one cycle, answer on the second edge
module oscillator_increment_regs
  import increment_regs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [increment_regs_pkg::addr_width-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  input wire logic fast_osc_i,
  input wire logic logic_cell_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic [19:0] active_increment_o,
  output logic load_pulse_o
);
  logic [7:0] low_ff;
  logic [7:0] high_ff;
  logic [3:0] upper_ff;
  logic [1:0] select_ff;
  logic pending_ff;
  logic ack_ff;
  logic [19:0] buffer_ff;
  logic load_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic accept;
  logic wr_en;
  logic wr_low;
  source_edge_if edge_bus();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the write and read paths
  function automatic logic hit(
    input logic [addr_width-1:0] addr,
    input logic [3:0] offset
  );
    hit = (addr == offset);
  endfunction

  // Read word; unmapped offsets and unused bits come back as zero
  function automatic logic [31:0] read_word(
    input logic [addr_width-1:0] addr,
    input logic [7:0] low,
    input logic [7:0] high,
    input logic [3:0] upper,
    input logic [1:0] select
  );
    read_word = 32'h0;
    if (hit(addr, low_offset))
      read_word = {24'h0, low};
    else if (hit(addr, high_offset))
      read_word = {24'h0, high};
    else if (hit(addr, upper_offset))
      read_word = {28'h0, upper};
    else if (hit(addr, control_offset))
      read_word = {30'h0, select};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle then accept
  // A fixed single wait keeps read data registered, at the cost of a cycle
  assign req = read_i | write_i;
  assign accept = req & ack_ff;
  assign wr_en = accept & write_i & byteenable_i[0];
  assign wr_low = wr_en & hit(address_i, low_offset);

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ack_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      waitrequest_o <= 1'b1;
    end
    else if (ce_i)
    begin
      waitrequest_o <= ~(req & ~ack_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low byte: all eight bits readable and writable
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      low_ff <= low_reset;
    end
    else if (ce_i && wr_en && hit(address_i, low_offset))
    begin
      low_ff <= writedata_i[7:0];
    end
  end

  // High byte
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      high_ff <= high_reset;
    end
    else if (ce_i && wr_en && hit(address_i, high_offset))
    begin
      high_ff <= writedata_i[7:0];
    end
  end

  // Upper register: only the low nibble exists
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      upper_ff <= upper_reset;
    end
    else if (ce_i && wr_en && hit(address_i, upper_offset))
    begin
      upper_ff <= writedata_i[3:0];
    end
  end

  // Source select
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      select_ff <= select_reset;
    end
    else if (ce_i && wr_en && hit(address_i, control_offset))
    begin
      select_ff <= writedata_i[1:0];
    end
  end

  // Read data is captured in the wait cycle and stands until the next request
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rdata_ff <= 32'h0;
    end
    else if (ce_i && req && !ack_ff)
    begin
      rdata_ff <= read_word(address_i, low_ff, high_ff, upper_ff, select_ff);
    end
  end
  assign readdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Double buffer: only low-byte write arms a transfer
  assign edge_bus.select = select_ff;
  assign edge_bus.fast_osc = fast_osc_i;
  assign edge_bus.logic_cell = logic_cell_i;

  source_edge_detect edge_unit (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .sel(edge_bus.detector)
  );

  // A new low write in the load cycle re-arms, so no request is lost
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      pending_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      pending_ff <= wr_low | (pending_ff & ~edge_bus.fall);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      buffer_ff <= {upper_reset, high_reset, low_reset};
    end
    else if (ce_i && pending_ff && edge_bus.fall)
    begin
      buffer_ff <= {upper_ff, high_ff, low_ff};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      load_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      load_ff <= pending_ff & edge_bus.fall;
    end
  end
  assign active_increment_o = buffer_ff;
  assign load_pulse_o = load_ff;
endmodule

// ==== verif/incr_sva.sv ====
// Purpose: increment port checks
// Assumes: reset held two cycles
// Notes: pulse marks each buffer change in the same cycle
`timescale 1ns/1ps
module incr_sva
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic read_i,
  input wire logic [3:0] address_i,
  input wire logic waitrequest_o,
  input wire logic [31:0] readdata_o,
  input wire logic [19:0] active_increment_o,
  input wire logic load_pulse_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  reset_state_a: assert property (disable iff (1'b0)
    srst_i |=> active_increment_o == 20'h00001 && !load_pulse_o) else $error("bad reset");
  load_flag_a: assert property (
    $changed(active_increment_o) |-> ##[0:1] load_pulse_o) else $error("no load pulse");
  buffer_hold_a: assert property (
    !load_pulse_o |-> $stable(active_increment_o)) else $error("buffer moved without load");
  pulse_single_a: assert property (
    load_pulse_o && ce_i |=> !load_pulse_o) else $error("load pulse too long");
  upper_read_a: assert property (
    !waitrequest_o && read_i && address_i == 4'h8 |-> readdata_o[31:4] == 28'h0)
    else $error("upper bits not zero");
  byte_read_a: assert property (
    !waitrequest_o && read_i |-> readdata_o[31:8] == 24'h0) else $error("read above byte");
endmodule

// ==== verif/testbench.sv ====
// Purpose: increment register bench
// Assumes: lane 0 held high; ce_i high except in the frozen step
// Notes: rg mirrors the bytes
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 0, srst_i = 1, ce_i = 1, read_i = 0, write_i = 0, waitrequest_o;
  logic fast_osc_i = 0, logic_cell_i = 0, load_pulse_o;
  logic [3:0] byteenable_i = 4'h1, address_i = 4'h0;
  logic [31:0] writedata_i = 32'h0, readdata_o;
  logic [19:0] active_increment_o, want = 20'h00001;
  logic [7:0] rg [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
  logic [1:0] src [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
  int mismatches = 0, check_count = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  oscillator_increment_regs dut (.*);
  task automatic chk(string nm, logic [31:0] seen, exp);
    check_count++;
    mismatches += int'(seen !== exp);
    if (seen !== exp)
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
  endtask
  task automatic bus(logic [3:0] a, logic w, logic [7:0] d);
    @(posedge sys_clk_i);
    {address_i, writedata_i, write_i, read_i} <= {a, 24'h0, d, w, !w};
    @(posedge sys_clk_i);
    while (waitrequest_o !== 1'b0)
      @(posedge sys_clk_i);
    {write_i, read_i} <= 2'b00;
    if (w && a[1:0] == 2'b00)
      rg[a[3:2]] = d & (a == 4'h8 ? 8'h0f : 8'hff);
  endtask
  task automatic act(string nm, int n);
    repeat (n) @(posedge sys_clk_i);
    chk(nm, 32'(active_increment_o), 32'(want));
  endtask
  task automatic print_verdict;
    $display("%0d checks %0d mismatches", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h90869c9b));
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    foreach (src[i])
    begin
      for (int a = 0; a < 16; a += 2)
      begin
        bus(4'(a), 1'b0, 8'h00);
        chk("read", readdata_o, a % 4 ? 32'h0 : {24'h0, rg[a / 4]});
      end
      bus(4'hc, 1'b1, {6'h0, src[i]});
      bus(4'h8, 1'b1, 8'($urandom));
      bus(4'h4, 1'b1, 8'($urandom));
      act("held", 3);
      bus(4'h0, 1'b1, 8'($urandom));
      if (src[i] != 2'h1)
        act("wait", 4);
      {fast_osc_i, logic_cell_i} <= 2'b11;
      @(posedge sys_clk_i);
      {fast_osc_i, logic_cell_i} <= 2'b00;
      want = src[i] == 2'h3 ? want : {rg[2][3:0], rg[1], rg[0]};
      act("load", 4);
    end
    bus(4'h0, 1'b1, 8'($urandom));
    {ce_i, logic_cell_i} <= 2'b01;
    @(posedge sys_clk_i);
    logic_cell_i <= 1'b0;
    act("frozen", 4);
    {ce_i, logic_cell_i} <= 2'b11;
    @(posedge sys_clk_i);
    logic_cell_i <= 1'b0;
    want = {rg[2][3:0], rg[1], rg[0]};
    act("thaw", 4);
    print_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk_i);
    mismatches++;
    print_verdict();
  end
endmodule
bind oscillator_increment_regs incr_sva sva (.*);
